// *** orm_pkg.sv ***
// Constants and types for the output run and margin control block
package orm_pkg;
  localparam logic [7:0] ORM_ADDR_RUN = 8'h01;
  localparam logic [7:0] ORM_ADDR_CFG = 8'h02;
  localparam int ORM_ON_BIT = 7;
  localparam int ORM_SOFT_BIT = 6;
  localparam int ORM_MRG_HI = 5;
  localparam int ORM_MRG_LO = 2;
  localparam logic [7:0] ORM_RUN_WMASK = 8'hfc;
  localparam logic [7:0] ORM_RUN_RST = 8'h00;
  localparam int ORM_PU_BIT = 4;
  localparam int ORM_CMD_BIT = 3;
  localparam int ORM_CPR_BIT = 2;
  localparam int ORM_POL_BIT = 1;
  localparam int ORM_CPA_BIT = 0;
  localparam logic [4:0] ORM_CFG_RST = 5'h16;
  localparam logic [3:0] ORM_M_NOM = 4'h0;
  localparam logic [3:0] ORM_M_NOM_IGN = 4'h1;
  localparam logic [3:0] ORM_M_NOM_2 = 4'h2;
  localparam logic [3:0] ORM_M_NOM_3 = 4'h3;
  localparam logic [3:0] ORM_M_LO_IGN = 4'h5;
  localparam logic [3:0] ORM_M_LO_ACT = 4'h6;
  localparam logic [3:0] ORM_M_HI_IGN = 4'h9;
  localparam logic [3:0] ORM_M_HI_ACT = 4'ha;
  typedef enum logic [1:0] {ORM_SRC_NOM = 2'b00, ORM_SRC_LO = 2'b01,
                            ORM_SRC_HI = 2'b11} orm_src_e;
  typedef enum logic [1:0] {ORM_ST_OFF = 2'b00, ORM_ST_RUN = 2'b01,
                            ORM_ST_WAIT = 2'b11, ORM_ST_RAMP = 2'b10} orm_state_e;
endpackage

// *** orm_margin_decode.sv ***
// Margin field decoder and target voltage arithmetic
`timescale 1ns/1ps
`default_nettype none
module orm_margin_decode
  import orm_pkg::*;
#(
  parameter int VW = 16
) (
  input wire logic [3:0] code_in,
  input wire logic [VW-1:0] nominal_in,
  input wire logic signed [VW-1:0] trim_in,
  input wire logic signed [VW-1:0] step_lo_in,
  input wire logic signed [VW-1:0] step_hi_in,
  input wire logic [VW-1:0] loop_scale_in,
  output logic [1:0] src_out,
  output logic ignore_faults_out,
  output logic invalid_out,
  output logic [VW-1:0] target_out
);
  logic signed [VW+1:0] offs;
  logic signed [VW+1:0] quot;
  always_comb begin
    src_out = ORM_SRC_NOM;
    ignore_faults_out = 1'b0;
    invalid_out = 1'b0;
    case (code_in)
      ORM_M_NOM, ORM_M_NOM_2, ORM_M_NOM_3: src_out = ORM_SRC_NOM;
      ORM_M_NOM_IGN: ignore_faults_out = 1'b1;
      ORM_M_LO_IGN: begin
        src_out = ORM_SRC_LO;
        ignore_faults_out = 1'b1;
      end
      ORM_M_LO_ACT: src_out = ORM_SRC_LO;
      ORM_M_HI_IGN: begin
        src_out = ORM_SRC_HI;
        ignore_faults_out = 1'b1;
      end
      ORM_M_HI_ACT: src_out = ORM_SRC_HI;
      default: invalid_out = 1'b1;
    endcase
  end
  always_comb begin
    offs = '0;
    if (src_out == ORM_SRC_LO) begin
      offs = (VW+2)'(trim_in) - (VW+2)'(step_lo_in);
    end else if (src_out == ORM_SRC_HI) begin
      offs = (VW+2)'(trim_in) + (VW+2)'(step_hi_in);
    end
    // Zero scale would divide by zero; treat it as unity
    if (loop_scale_in == '0) begin
      quot = offs;
    end else begin
      quot = offs / $signed({2'b00, loop_scale_in});
    end
    target_out = nominal_in + quot[VW-1:0];
  end
endmodule
`default_nettype wire

// *** orm_off_timer.sv ***
// Turn-off wait and ramp sequencer counting one step per reference clock cycle
`timescale 1ns/1ps
`default_nettype none
module orm_off_timer
  import orm_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic [CW-1:0] wait_in,
  input wire logic [CW-1:0] ramp_in,
  output logic busy_out,
  output logic ramping_out,
  output logic done_out
);
  orm_state_e st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic done_d, done_q;
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    case (st_q)
      ORM_ST_OFF, ORM_ST_RUN: begin
        if (start_in) begin
          st_d = ORM_ST_WAIT;
          cnt_d = wait_in;
        end
      end
      ORM_ST_WAIT: begin
        if (cnt_q == '0) begin
          st_d = ORM_ST_RAMP;
          cnt_d = ramp_in;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ORM_ST_RAMP: begin
        if (cnt_q == '0) begin
          st_d = ORM_ST_OFF;
          done_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: st_d = ORM_ST_OFF;
    endcase
    if (abort_in) begin
      st_d = ORM_ST_OFF;
      cnt_d = '0;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_q <= ORM_ST_OFF;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end
  assign busy_out = (st_q == ORM_ST_WAIT) || (st_q == ORM_ST_RAMP);
  assign ramping_out = (st_q == ORM_ST_RAMP);
  assign done_out = done_q;
endmodule
`default_nettype wire

// *** orm_output_run_margin_control.sv ***
// Run-control and start-source registers with switching decision
`timescale 1ns/1ps
`default_nettype none
module orm_output_run_margin_control
  import orm_pkg::*;
#(
  parameter int VW = 16,
  parameter int CW = 16
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic nack_out,
  input wire logic loop_slave_in,
  input wire logic [4:0] nv_cfg_in,
  input wire logic nv_load_in,
  input wire logic control_pin_in,
  input wire logic above_lockout_in,
  input wire logic fault_in,
  input wire logic overvoltage_fault_in,
  input wire logic undervoltage_fault_in,
  input wire logic [1:0] alert_suppress_bits_in,
  input wire logic fault_clear_in,
  input wire logic [CW-1:0] turn_off_wait_in,
  input wire logic [CW-1:0] turn_off_ramp_in,
  input wire logic [VW-1:0] nominal_voltage_setting_in,
  input wire logic signed [VW-1:0] trim_in,
  input wire logic signed [VW-1:0] step_lo_in,
  input wire logic signed [VW-1:0] step_hi_in,
  input wire logic [VW-1:0] loop_scale_in,
  output logic switching_out,
  output logic drivers_off_out,
  output logic ramping_out,
  output logic [VW-1:0] target_out,
  output logic protect_act_out,
  output logic comm_fault_out,
  output logic bad_data_out,
  output logic bad_command_fault_out,
  output logic overvoltage_status_out,
  output logic undervoltage_status_out,
  output logic alert_out
);
  logic [7:0] run_q, run_d;
  logic [4:0] cfg_q, cfg_d;
  logic pol_q, pol_d;
  logic cml_q, cml_d, ivd_q, ivd_d, ivc_q, ivc_d;
  logic ovs_q, ovs_d, uvs_q, uvs_d;
  logic sw_q, sw_d;
  logic [7:0] rdata_q, rdata_d;
  logic pin_q;
  logic [1:0] src;
  logic ign_f, mrg_bad;
  logic [VW-1:0] tgt;
  logic [3:0] new_code;
  logic hit_run, hit_cfg, both_bits;
  logic pin_act, want_on, stop_req, soft_stop, t_busy, t_ramp, t_done;

  function automatic logic is_reg(input logic [7:0] a);
    is_reg = (a == ORM_ADDR_RUN) || (a == ORM_ADDR_CFG);
  endfunction

  assign hit_run = wr_en_in && (addr_in == ORM_ADDR_RUN) && !loop_slave_in;
  assign hit_cfg = wr_en_in && (addr_in == ORM_ADDR_CFG) && !loop_slave_in;
  assign both_bits = wdata_in[ORM_ON_BIT] && wdata_in[ORM_SOFT_BIT];
  assign new_code = wdata_in[ORM_MRG_HI:ORM_MRG_LO];

  orm_margin_decode #(.VW(VW)) u_dec (
    .code_in(run_q[ORM_MRG_HI:ORM_MRG_LO]),
    .nominal_in(nominal_voltage_setting_in),
    .trim_in(trim_in),
    .step_lo_in(step_lo_in),
    .step_hi_in(step_hi_in),
    .loop_scale_in(loop_scale_in),
    .src_out(src),
    .ignore_faults_out(ign_f),
    .invalid_out(),
    .target_out(tgt)
  );

  // Second decode of the incoming code catches invalid margin writes
  orm_margin_decode #(.VW(VW)) u_chk (
    .code_in(new_code),
    .nominal_in(nominal_voltage_setting_in),
    .trim_in(trim_in),
    .step_lo_in(step_lo_in),
    .step_hi_in(step_hi_in),
    .loop_scale_in(loop_scale_in),
    .src_out(),
    .ignore_faults_out(),
    .invalid_out(mrg_bad),
    .target_out()
  );

  // Register writes and status flags; set wins over clear
  always_comb begin
    run_d = run_q;
    cfg_d = cfg_q;
    pol_d = pol_q;
    cml_d = fault_clear_in ? 1'b0 : cml_q;
    ivd_d = fault_clear_in ? 1'b0 : ivd_q;
    ivc_d = fault_clear_in ? 1'b0 : ivc_q;
    ovs_d = fault_clear_in ? 1'b0 : ovs_q;
    uvs_d = fault_clear_in ? 1'b0 : uvs_q;
    rdata_d = rdata_q;
    if (hit_run) begin
      if (both_bits || mrg_bad) begin
        cml_d = 1'b1;
        ivd_d = 1'b1;
      end else begin
        run_d = (wdata_in & ORM_RUN_WMASK) | (run_q & ~ORM_RUN_WMASK);
      end
    end
    if (hit_cfg) begin
      cfg_d = wdata_in[4:0];
    end
    if (nv_load_in) begin
      cfg_d = nv_cfg_in;
      pol_d = nv_cfg_in[ORM_POL_BIT];
    end
    if ((wr_en_in || rd_en_in) && is_reg(addr_in) && loop_slave_in) begin
      cml_d = 1'b1;
      ivc_d = 1'b1;
    end
    if (overvoltage_fault_in) begin
      ovs_d = 1'b1;
    end
    if (undervoltage_fault_in) begin
      uvs_d = 1'b1;
    end
    if (rd_en_in && !loop_slave_in) begin
      if (addr_in == ORM_ADDR_RUN) begin
        rdata_d = run_q;
      end else if (addr_in == ORM_ADDR_CFG) begin
        rdata_d = {3'b000, cfg_q};
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  // Start decision: polarity comes only from the latched power-up copy
  assign pin_act = (control_pin_in == pol_q);
  always_comb begin
    if (!cfg_q[ORM_PU_BIT]) begin
      want_on = 1'b1;
    end else begin
      want_on = (!cfg_q[ORM_CMD_BIT] || run_q[ORM_ON_BIT])
             && (!cfg_q[ORM_CPR_BIT] || pin_act);
      if (!cfg_q[ORM_CMD_BIT] && !cfg_q[ORM_CPR_BIT]) begin
        want_on = 1'b0;
      end
    end
  end
  assign stop_req = sw_q && !want_on;
  // Bus-commanded off uses the soft bit, pin-commanded off the style bit
  assign soft_stop = (cfg_q[ORM_CMD_BIT] && !run_q[ORM_ON_BIT])
                   ? run_q[ORM_SOFT_BIT]
                   : !cfg_q[ORM_CPA_BIT];

  orm_off_timer #(.CW(CW)) u_tmr (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .start_in(stop_req && soft_stop && !t_busy && !t_done),
    .abort_in(want_on || fault_in),
    .wait_in(turn_off_wait_in),
    .ramp_in(turn_off_ramp_in),
    .busy_out(t_busy),
    .ramping_out(t_ramp),
    .done_out(t_done)
  );

  always_comb begin
    sw_d = sw_q;
    if (want_on && above_lockout_in && !fault_in) begin
      sw_d = 1'b1;
    end else if (!above_lockout_in || fault_in) begin
      sw_d = 1'b0;
    end else if (stop_req && !soft_stop) begin
      sw_d = 1'b0;
    end else if (t_done) begin
      sw_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      run_q <= ORM_RUN_RST;
      cfg_q <= ORM_CFG_RST;
      pol_q <= ORM_CFG_RST[ORM_POL_BIT];
      cml_q <= 1'b0;
      ivd_q <= 1'b0;
      ivc_q <= 1'b0;
      ovs_q <= 1'b0;
      uvs_q <= 1'b0;
      sw_q <= 1'b0;
      rdata_q <= 8'h00;
      pin_q <= 1'b0;
    end else begin
      run_q <= run_d;
      cfg_q <= cfg_d;
      pol_q <= pol_d;
      cml_q <= cml_d;
      ivd_q <= ivd_d;
      ivc_q <= ivc_d;
      ovs_q <= ovs_d;
      uvs_q <= uvs_d;
      sw_q <= sw_d;
      rdata_q <= rdata_d;
      pin_q <= control_pin_in;
    end
  end

  assign rdata_out = rdata_q;
  assign nack_out = (wr_en_in || rd_en_in) && is_reg(addr_in) && loop_slave_in;
  assign switching_out = sw_q;
  assign drivers_off_out = !sw_q;
  assign ramping_out = t_ramp;
  assign target_out = tgt;
  assign protect_act_out = !ign_f;
  assign comm_fault_out = cml_q;
  assign bad_data_out = ivd_q;
  assign bad_command_fault_out = ivc_q;
  assign overvoltage_status_out = ovs_q;
  assign undervoltage_status_out = uvs_q;
  assign alert_out = cml_q || (ovs_q && !alert_suppress_bits_in[1])
                  || (uvs_q && !alert_suppress_bits_in[0]);

  chk_both_bits_flag: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    hit_run && both_bits |=> bad_data_out && comm_fault_out && alert_out)
    else $error("on+soft write not flagged");
  chk_both_bits_kept: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    hit_run && both_bits |=> $stable(run_q))
    else $error("invalid run write stored");
  chk_ro_bits: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ##1 run_q[1:0] == $past(run_q[1:0]))
    else $error("read-only bits changed");
  chk_bad_margin: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    hit_run && !both_bits && mrg_bad |=> bad_data_out)
    else $error("bad margin code not flagged");
  chk_slave_nack: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    wr_en_in && is_reg(addr_in) && loop_slave_in |-> nack_out ##1 bad_command_fault_out)
    else $error("slave access not refused");
  chk_slave_ignore: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    loop_slave_in && !nv_load_in |=> $stable(run_q) && $stable(cfg_q))
    else $error("slave write changed register");
  chk_ov_status: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    overvoltage_fault_in && !alert_suppress_bits_in[1] |=> alert_out)
    else $error("ov event did not alert");
  chk_off_drivers: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !above_lockout_in |=> drivers_off_out)
    else $error("switching below lockout");
  chk_hard_stop: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    stop_req && !soft_stop && above_lockout_in && !fault_in |=> !switching_out)
    else $error("hard stop did not stop");
  chk_pu_zero: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !cfg_q[ORM_PU_BIT] && above_lockout_in && !fault_in |=> switching_out)
    else $error("always-on policy did not run");
  cov_soft_off: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in) t_done);
  cov_margin_hi: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    switching_out && src == ORM_SRC_HI);
  cov_pin_edge: cover property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    pin_q != control_pin_in && switching_out);
endmodule
`default_nettype wire

// *** orm_host_model.sv ***
// Bus host and control pin driver facing the run-control block
`timescale 1ns/1ps
`default_nettype none
module orm_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic nack_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic pin_out
);
  initial begin
    wr_en_out = 1'h0;
    rd_en_out = 1'h0;
    addr_out = 8'hff;
    wdata_out = 8'h00;
    pin_out = 1'h0;
  end

  // One strobed byte; released lines show the inverse so stale data never matches
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output logic nk);
    @(posedge clk_in);
    wr_en_out <= wr;
    rd_en_out <= !wr;
    addr_out <= a;
    wdata_out <= d;
    #1 nk = nack_in;
    @(posedge clk_in);
    wr_en_out <= 1'h0;
    rd_en_out <= 1'h0;
    addr_out <= ~a;
    wdata_out <= ~d;
    #1 rd = rdata_in;
  endtask

  task automatic set_pin(input logic v);
    @(posedge clk_in);
    pin_out <= v;
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the run-control and start-source registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import orm_pkg::*;
  typedef struct packed {logic [3:0] code; logic [15:0] tgt; logic prot; logic bad;} orm_row_s;
  logic clk, rst, wr, rd, slave, nv_load, pin, above, flt, ov, uv, fclr, nk;
  logic sw, doff, ramp, prot, cml, ivd, bad_command_fault, ovs, uvs, alert, nack;
  logic [7:0] addr, wdata, rdata, rv;
  logic [4:0] nv_cfg;
  logic [1:0] sup;
  logic [15:0] twait, tramp, nom, trim, slo, shi, scl, tgt;
  int mismatches, tests_run, n;
  orm_row_s rows[16];

  orm_output_run_margin_control u_dut (.ref_clk_in(clk), .sys_rst_in(rst), .wr_en_in(wr),
    .rd_en_in(rd), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .nack_out(nack),
    .loop_slave_in(slave), .nv_cfg_in(nv_cfg), .nv_load_in(nv_load), .control_pin_in(pin),
    .above_lockout_in(above), .fault_in(flt), .overvoltage_fault_in(ov),
    .undervoltage_fault_in(uv), .alert_suppress_bits_in(sup), .fault_clear_in(fclr),
    .turn_off_wait_in(twait), .turn_off_ramp_in(tramp), .nominal_voltage_setting_in(nom),
    .trim_in(trim), .step_lo_in(slo), .step_hi_in(shi), .loop_scale_in(scl),
    .switching_out(sw), .drivers_off_out(doff), .ramping_out(ramp), .target_out(tgt),
    .protect_act_out(prot), .comm_fault_out(cml), .bad_data_out(ivd),
    .bad_command_fault_out(bad_command_fault), .overvoltage_status_out(ovs),
    .undervoltage_status_out(uvs), .alert_out(alert));

  orm_host_model u_host (.clk_in(clk), .rdata_in(rdata), .nack_in(nack), .wr_en_out(wr),
    .rd_en_out(rd), .addr_out(addr), .wdata_out(wdata), .pin_out(pin));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic conclude;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    u_host.access(1'h1, a, d, rv, nk);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    u_host.access(1'h0, a, 8'h00, rv, nk);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic clr;
    @(posedge clk);
    fclr <= 1'h1;
    @(posedge clk);
    fclr <= 1'h0;
    #1;
  endtask

  task automatic ev(input logic o, input logic u);
    @(posedge clk);
    ov <= o;
    uv <= u;
    @(posedge clk);
    ov <= 1'h0;
    uv <= 1'h0;
    #1;
  endtask

  // Bounded wait on the switching output; running out ends the run
  task automatic wait_sw(input logic e);
    n = 0;
    while (sw !== e && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (sw !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t switching wait ran out", $time);
      conclude();
    end
  endtask

  initial begin
    {rst, slave, nv_load, above, flt, ov, uv, fclr} = 8'h90;
    {nv_cfg, sup, mismatches, tests_run} = '0;
    twait = 16'h0003;
    tramp = 16'h0004;
    nom = 16'h03e8;
    trim = 16'h000a;
    slo = 16'h0004;
    shi = 16'h0006;
    scl = 16'h0002;
    // Nominal 1000, low 1000+(10-4)/2, high 1000+(10+6)/2
    rows = '{'{4'h0, 16'h03e8, 1'h1, 1'h0}, '{4'h1, 16'h03e8, 1'h0, 1'h0},
             '{4'h2, 16'h03e8, 1'h1, 1'h0}, '{4'h3, 16'h03e8, 1'h1, 1'h0},
             '{4'h4, 16'h0000, 1'h0, 1'h1}, '{4'h5, 16'h03eb, 1'h0, 1'h0},
             '{4'h6, 16'h03eb, 1'h1, 1'h0}, '{4'h7, 16'h0000, 1'h0, 1'h1},
             '{4'h8, 16'h0000, 1'h0, 1'h1}, '{4'h9, 16'h03f0, 1'h0, 1'h0},
             '{4'ha, 16'h03f0, 1'h1, 1'h0}, '{4'hb, 16'h0000, 1'h0, 1'h1},
             '{4'hc, 16'h0000, 1'h0, 1'h1}, '{4'hd, 16'h0000, 1'h0, 1'h1},
             '{4'he, 16'h0000, 1'h0, 1'h1}, '{4'hf, 16'h0000, 1'h0, 1'h1}};
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      clr();
      wr_reg(ORM_ADDR_RUN, 8'h00);
      wr_reg(ORM_ADDR_RUN, {2'h0, rows[i].code, 2'h0});
      check(ivd, rows[i].bad, "bad data flag");
      check(cml, rows[i].bad, "comm fault flag");
      rd_reg(ORM_ADDR_RUN);
      check(rv, rows[i].bad ? 8'h00 : {2'h0, rows[i].code, 2'h0}, "margin readback");
      if (!rows[i].bad) begin
        check(tgt, rows[i].tgt, "target");
        check(prot, rows[i].prot, "protection action");
      end
    end
    // Negative trim: 1000+(-8+6)/2
    @(posedge clk);
    trim <= 16'hfff8;
    wr_reg(ORM_ADDR_RUN, 8'h28);
    check(tgt, 16'h03e7, "signed target");
    clr();
    wr_reg(ORM_ADDR_RUN, 8'h24);
    ev(1'h1, 1'h0);
    check({ovs, alert, prot}, 16'h0006, "ignored ov still flags");
    clr();
    @(posedge clk);
    sup <= 2'h1;
    ev(1'h0, 1'h1);
    check({uvs, alert}, 16'h0002, "masked uv alert");
    wr_reg(ORM_ADDR_RUN, 8'h0b);
    rd_reg(ORM_ADDR_RUN);
    check(rv, 8'h08, "run low bits read-only");
    wr_reg(ORM_ADDR_RUN, 8'hc0);
    check({ivd, cml, alert}, 16'h0007, "on and soft-off together");
    rd_reg(ORM_ADDR_RUN);
    check(rv, 8'h08, "invalid write not stored");
    wr_reg(ORM_ADDR_CFG, 8'hff);
    rd_reg(ORM_ADDR_CFG);
    check(rv, 8'h1f, "config top bits read-only");
    wr_reg(8'h05, 8'h80);
    rd_reg(8'h05);
    check(rv, 8'h00, "unmapped read");
    @(posedge clk);
    slave <= 1'h1;
    clr();
    wr_reg(ORM_ADDR_RUN, 8'h80);
    check({nk, bad_command_fault, alert}, 16'h0007, "slave write refused");
    rd_reg(ORM_ADDR_CFG);
    check(nk, 1'h1, "slave read refused");
    @(posedge clk);
    slave <= 1'h0;
    rd_reg(ORM_ADDR_RUN);
    check(rv, 8'h08, "slave write ignored");
    // Reset in mid-run restores defaults over written values
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd_reg(ORM_ADDR_RUN);
    check(rv, 8'h00, "run reset value");
    rd_reg(ORM_ADDR_CFG);
    check(rv, {3'h0, ORM_CFG_RST}, "config reset value");
    check({sw, doff, ivd, cml, bad_command_fault}, 16'h0008, "outputs after reset");
    u_host.set_pin(1'h1);
    wait_sw(1'h1);
    u_host.set_pin(1'h0);
    cyc(2);
    check(sw, 1'h1, "pin off uses delay");
    wait_sw(1'h0);
    wr_reg(ORM_ADDR_CFG, 8'h12);
    wr_reg(ORM_ADDR_RUN, 8'h80);
    cyc(3);
    check(sw, 1'h0, "on bit disregarded");
    @(posedge clk);
    above <= 1'h0;
    wr_reg(ORM_ADDR_CFG, 8'h1a);
    cyc(3);
    check(sw, 1'h0, "below lockout");
    @(posedge clk);
    above <= 1'h1;
    wait_sw(1'h1);
    @(posedge clk);
    flt <= 1'h1;
    wait_sw(1'h0);
    @(posedge clk);
    flt <= 1'h0;
    wait_sw(1'h1);
    wr_reg(ORM_ADDR_RUN, 8'h00);
    cyc(1);
    check({sw, doff}, 16'h0001, "immediate off");
    wr_reg(ORM_ADDR_RUN, 8'h80);
    wait_sw(1'h1);
    wr_reg(ORM_ADDR_RUN, 8'h40);
    cyc(6);
    check({sw, ramp}, 16'h0003, "soft off delay and ramp");
    wait_sw(1'h0);
    wr_reg(ORM_ADDR_CFG, 8'h00);
    wait_sw(1'h1);
    cyc(5);
    check(sw, 1'h1, "mode holds");
    // Polarity only follows a stored load, never a bus write
    @(posedge clk);
    nv_cfg <= 5'h14;
    nv_load <= 1'h1;
    @(posedge clk);
    nv_load <= 1'h0;
    wait_sw(1'h1);
    u_host.set_pin(1'h1);
    wait_sw(1'h0);
    wr_reg(ORM_ADDR_CFG, 8'h16);
    cyc(3);
    check(sw, 1'h0, "polarity write has no effect");
    conclude();
  end
endmodule
`default_nettype wire
